// file: address_stepper.sv
// Next transfer address: increment, displacement, repeat-area reload, short range
`timescale 1ns/1ps
`default_nettype none

module address_stepper (
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  sz,
	input  wire logic        inc,
	input  wire logic        disp_en,
	input  wire logic [31:0] disp,
	input  wire logic        reload,
	input  wire logic [31:0] area,
	input  wire logic        short_mode,
	output logic      [31:0] nxt_addr
);
	logic [31:0] sum;

	// Reload takes back a whole area, landing on the start address again
	always_comb begin
		sum = addr;
		if (inc)
			sum = sum + (32'h0000_0001 << sz);
		if (disp_en)
			sum = sum + disp;
		if (reload)
			sum = sum - area;
		nxt_addr = short_mode ? {{8{sum[23]}}, sum[23:0]} : sum;
	end
endmodule // address_stepper

`default_nettype wire

// file: engine_consts.svh
// Named offsets, field positions, sizes, response codes and counts of the transfer engine
`ifndef ENGINE_CONSTS_SVH
`define ENGINE_CONSTS_SVH
`define NCH          8
`define CHW          3
// Register byte offsets
`define OFF_OPER     8'h00
`define OFF_VBASE    8'h04
`define OFF_IBASE    8'h08
`define OFF_SEQEN    8'h0C
`define OFF_DISP     8'h10
`define OFF_STAT     8'h14
// operation_reg fields
`define OP_STOP      0
`define OP_RSKIP     1
// sequence_enable_reg fields
`define SQ_EN        7
`define SQ_CH        2:0
// Descriptor word 0: descriptor_mode_a, descriptor_mode_b, descriptor_mode_c
`define MA_MODE      31:30
`define MA_SZ        29:28
`define MA_SINC      27
`define MA_WRITEBACK_DISABLE_BIT     26
`define MA_SHORT     25
`define MB_CHAIN     23
`define MB_CHZERO    22
`define MB_DINC      21
`define MB_RPTDST    20
`define MB_SEQUENCE_END_BIT     19
`define MB_INDEX_TABLE_REF_BIT      18
`define MB_IRQEACH   17
`define MC_DISP      8
// Descriptor layout and sizes
`define W_MODE       2'h0
`define W_SRC        2'h1
`define W_DST        2'h2
`define W_CNT        2'h3
`define DESC_BYTES   32'h0000_0010
`define AREA_FULL    9'h100
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// file: engine_pkg.sv
// Types shared by the transfer engine modules
package engine_pkg;
	typedef enum logic [1:0] {XFER_NORMAL, XFER_REPEAT, XFER_BLOCK} xfer_mode_e;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} unit_size_e;
	typedef enum logic [2:0] {ST_IDLE, ST_DREAD, ST_SRD, ST_DWR, ST_SEL, ST_WB, ST_NEXT} eng_state_e;
	typedef struct packed {
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_cmd_s;
endpackage

// file: engine_props.sv
// Port checker of the transfer engine, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "engine_consts.svh"

module engine_props
	import engine_pkg::*;
(
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic [`NCH-1:0] cpu_irq_ff,
	input wire logic            m_req_ff,
	input wire mem_cmd_s        m_cmd_ff,
	input wire logic            m_ack,
	input wire logic [7:0]      s_axi_awaddr,
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic [1:0]      s_axi_bresp,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic [7:0]      s_axi_araddr,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic [1:0]      s_axi_rresp,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// Address and data taken at one edge, then the answer
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_err;
		s_axi_bvalid && s_axi_bresp == `RESP_SLVERR;
	endsequence
	property p_b_answer;
		s_wr_taken |-> ##[1:2] s_axi_bvalid;
	endproperty
	property p_status_ro;
		(s_wr_taken ##0 s_axi_awaddr == `OFF_STAT) |-> ##[1:2] s_b_err;
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_r_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFF_STAT |=>
			s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	// A main-bus request may not move until memory takes it
	property p_req_hold;
		m_req_ff && !m_ack |=> m_req_ff && $stable(m_cmd_ff);
	endproperty
	property p_irq_pulse;
		|cpu_irq_ff |=> cpu_irq_ff == '0;
	endproperty
	property p_size_legal;
		m_req_ff |-> m_cmd_ff.size != 2'h3;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write not answered");
	a_status_ro: assert property (p_status_ro) else $error("status write accepted");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_r_answer: assert property (p_r_answer) else $error("read not answered");
	a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read ok");
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	a_size_legal: assert property (p_size_legal) else $error("bad unit size");
endmodule // engine_props

bind transfer_engine engine_props engine_props_inst (.*);
`default_nettype wire

// file: main_mem_model.sv
// Main-bus memory that answers after a chosen number of idle cycles
`timescale 1ns/1ps
`default_nettype none

module main_mem_model
	import engine_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [1:0]  slow,
	input  wire logic        m_req_ff,
	input  wire mem_cmd_s    m_cmd_ff,
	output logic             m_ack,
	output logic      [31:0] m_rdata
);
	logic [7:0] mem [1024];
	logic [1:0] wait_ff;
	logic [9:0] a;

	assign a = m_cmd_ff.addr[9:0];
	// Blank memory reads as all ones so an untouched word stands out
	initial begin
		foreach (mem[k]) mem[k] = 8'hFF;
	end
	// One ack pulse per request; idle data toggles so a stale sample is caught
	always @(posedge aclk) begin
		if (!aresetn) begin
			m_ack <= 1'b0;
			wait_ff <= 2'h0;
			m_rdata <= 32'h0;
		end else if (m_req_ff && !m_ack && wait_ff == slow) begin
			m_ack <= 1'b1;
			wait_ff <= 2'h0;
			m_rdata <= {mem[a + 10'h3], mem[a + 10'h2], mem[a + 10'h1], mem[a]};
			for (int k = 0; k < 4; k++) begin
				if (m_cmd_ff.we && k < (1 << m_cmd_ff.size)) mem[a + k[9:0]] <= m_cmd_ff.wdata[8*k +: 8];
			end
		end else begin
			m_ack <= 1'b0;
			wait_ff <= (m_req_ff && !m_ack) ? wait_ff + 2'h1 : 2'h0;
			m_rdata <= ~m_rdata;
		end
	end
endmodule // main_mem_model
`default_nettype wire

// file: transfer_engine.sv
// Interrupt-triggered transfer engine: register slave, sequencer and main-bus master
// Operation
// - Every trigger input is its own channel with its own descriptor.
// - Normal mode moves one unit per activation and stops.
// - Repeat mode moves one unit; repeating address reloads after repeat size.
// - Repeat area holds up to 256 units, 1,024 bytes as longwords.
// - Block mode moves a whole block of 1 to 256 units.
// - Units are byte, word or longword.
// - Descriptors may chain and run in turn on one trigger.
// - Chaining happens every time or only when the count reaches zero.
// - Only one trigger source may use sequence transfer at a time.
// - A sequence trigger selects one of up to 256 sequences.
// - First transferred data value selects the sequence to run.
// - A sequence runs whole or pauses and resumes on the next trigger.
// - Short mode keeps addresses to the low or high 8 MB region.
// - Full mode uses the whole 32-bit address space.
// - CPU interrupt after each transfer or at count end; the code raises it only for descriptors not reached through a chain or the index table.
// - Descriptor re-read is skipped when the same transfer repeats.
// - Fixed source or destination words are not written back.
// - Write-back disable bit suppresses all descriptor write-back.
// - Optional displacement is added to the source address per descriptor.
// - Descriptors carry end and index bits; registers hold base, enable, displacement.
// - Module stop halts new activations to save power.
// - Memory traffic goes over a dedicated main bus on the system clock.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "engine_consts.svh"

module transfer_engine
	import engine_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`NCH-1:0]   trig_in,
	output logic      [`NCH-1:0]   cpu_irq_ff,
	output logic                   m_req_ff,
	output mem_cmd_s               m_cmd_ff,
	input  wire logic              m_ack,
	input  wire logic [31:0]       m_rdata,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic mem_cmd_s mk_cmd(input logic we, input logic [1:0] sz,
		input logic [31:0] a, input logic [31:0] d);
		mk_cmd = '{we: we, size: sz, addr: a, wdata: d};
	endfunction

	function automatic logic [31:0] unit_mask(input logic [1:0] sz);
		unit_mask = (sz == SZ_BYTE) ? 32'h0000_00FF :
			(sz == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	endfunction

	function automatic logic [31:0] sext_short(input logic [31:0] a);
		sext_short = {{8{a[23]}}, a[23:0]};
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] st);
		for (int i = 0; i < 4; i++)
			old[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		merge_strb = old;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register slave

	logic [1:0]          oper_ff;
	logic [31:0]         vbase_ff;
	logic [31:0]         ibase_ff;
	logic [7:0]          seqen_ff;
	logic [31:0]         disp_ff;
	logic                aw_got_ff;
	logic                w_got_ff;
	logic [7:0]          aw_addr_ff;
	logic [31:0]         w_data_ff;
	logic [3:0]          w_strb_ff;
	logic                wr_fire;
	logic [`NCH-1:0]     pend;
	eng_state_e          state_ff;
	logic                pause_ff;

	assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

	// Address and data are caught independently; the write happens once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h0000_0000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff     <= 1'b1;
				aw_addr_ff    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff     <= 1'b1;
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_ff > `OFF_DISP || aw_addr_ff[1:0] != 2'h0) ?
					`RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software-written configuration; one sequence field means one sequence source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oper_ff  <= 2'h0;
			vbase_ff <= 32'h0000_0000;
			ibase_ff <= 32'h0000_0000;
			seqen_ff <= 8'h00;
			disp_ff  <= 32'h0000_0000;
		end else if (wr_fire) begin
			unique case (aw_addr_ff)
				`OFF_OPER:  oper_ff  <= 2'(merge_strb({30'h0, oper_ff}, w_data_ff, w_strb_ff));
				`OFF_VBASE: vbase_ff <= merge_strb(vbase_ff, w_data_ff, w_strb_ff);
				`OFF_IBASE: ibase_ff <= merge_strb(ibase_ff, w_data_ff, w_strb_ff);
				`OFF_SEQEN: seqen_ff <= 8'(merge_strb({24'h0, seqen_ff}, w_data_ff, w_strb_ff));
				`OFF_DISP:  disp_ff  <= merge_strb(disp_ff, w_data_ff, w_strb_ff);
				default: ;
			endcase
		end
	end

	// Reads answer one cycle after the address; unmapped words give SLVERR and zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`OFF_OPER:  s_axi_rdata <= {30'h0, oper_ff};
				`OFF_VBASE: s_axi_rdata <= vbase_ff;
				`OFF_IBASE: s_axi_rdata <= ibase_ff;
				`OFF_SEQEN: s_axi_rdata <= {24'h0, seqen_ff};
				`OFF_DISP:  s_axi_rdata <= disp_ff;
				`OFF_STAT:  s_axi_rdata <= {15'h0, pause_ff, pend, 7'h0, state_ff != ST_IDLE};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Descriptor decode and per-unit arithmetic

	logic [31:0]         dw_ff [0:3];
	logic [31:0]         daddr_ff;
	logic [`CHW-1:0]     ch_ff;
	logic [1:0]          widx_ff;
	logic [31:0]         data_ff;
	logic                in_seq_ff;
	logic                chained_ff;
	logic [31:0]         resume_ff;
	logic                cache_ok_ff;
	logic [`CHW-1:0]     cache_ch_ff;
	logic                gnt_valid;
	logic [`CHW-1:0]     gnt_ch;
	logic                take;
	logic                seq_hit;
	logic [31:0]         vaddr;
	xfer_mode_e          md;
	logic [1:0]          sz;
	logic [15:0]         cra;
	logic [15:0]         crb;
	logic [7:0]          lo_dec;
	logic                rld;
	logic [31:0]         area;
	logic [15:0]         cra_n;
	logic [15:0]         crb_n;
	logic                cnt_done;
	logic [31:0]         src_n;
	logic [31:0]         dst_n;
	logic                src_fix;

	assign md      = xfer_mode_e'(dw_ff[`W_MODE][`MA_MODE]);
	assign sz      = dw_ff[`W_MODE][`MA_SZ];
	assign cra     = dw_ff[`W_CNT][31:16];
	assign crb     = dw_ff[`W_CNT][15:0];
	assign lo_dec  = cra[7:0] - 8'h01;
	// A size byte of zero stands for a full area of 256 units
	assign area    = {23'h0, (cra[15:8] == 8'h00) ? `AREA_FULL : {1'b0, cra[15:8]}} << sz;
	assign rld     = (md != XFER_NORMAL) && (lo_dec == 8'h00);
	assign cra_n   = (md == XFER_NORMAL) ? cra - 16'h0001 :
		{cra[15:8], rld ? cra[15:8] : lo_dec};
	assign crb_n   = (md == XFER_BLOCK && rld) ? crb - 16'h0001 : crb;
	assign cnt_done = (md == XFER_NORMAL) ? (cra == 16'h0000) :
		(md == XFER_BLOCK) ? (crb == 16'h0000) : 1'b0;
	assign src_fix = !dw_ff[`W_MODE][`MA_SINC] && !dw_ff[`W_MODE][`MC_DISP];
	assign seq_hit = seqen_ff[`SQ_EN] && (gnt_ch == seqen_ff[`SQ_CH]);
	assign vaddr   = vbase_ff + ({29'h0, gnt_ch} << 4);
	assign take    = (state_ff == ST_IDLE) && gnt_valid && !oper_ff[`OP_STOP];

	trigger_arbiter u_arb (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.trig      (trig_in),
		.take      (take),
		.take_ch   (gnt_ch),
		.pend_ff   (pend),
		.gnt_valid (gnt_valid),
		.gnt_ch    (gnt_ch)
	);

	address_stepper u_src (
		.addr       (dw_ff[`W_SRC]),
		.sz         (sz),
		.inc        (dw_ff[`W_MODE][`MA_SINC]),
		.disp_en    (dw_ff[`W_MODE][`MC_DISP]),
		.disp       (disp_ff),
		.reload     (rld && !dw_ff[`W_MODE][`MB_RPTDST]),
		.area       (area),
		.short_mode (dw_ff[`W_MODE][`MA_SHORT]),
		.nxt_addr   (src_n)
	);

	address_stepper u_dst (
		.addr       (dw_ff[`W_DST]),
		.sz         (sz),
		.inc        (dw_ff[`W_MODE][`MB_DINC]),
		.disp_en    (1'b0),
		.disp       (disp_ff),
		.reload     (rld && dw_ff[`W_MODE][`MB_RPTDST]),
		.area       (area),
		.short_mode (dw_ff[`W_MODE][`MA_SHORT]),
		.nxt_addr   (dst_n)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer and main-bus master; a request holds until the cycle of its ack

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff    <= ST_IDLE;
			m_req_ff    <= 1'b0;
			m_cmd_ff    <= '0;
			cpu_irq_ff  <= '0;
			daddr_ff    <= 32'h0000_0000;
			ch_ff       <= '0;
			widx_ff     <= 2'h0;
			data_ff     <= 32'h0000_0000;
			in_seq_ff   <= 1'b0;
			chained_ff  <= 1'b0;
			pause_ff    <= 1'b0;
			resume_ff   <= 32'h0000_0000;
			cache_ok_ff <= 1'b0;
			cache_ch_ff <= '0;
			for (int i = 0; i < 4; i++)
				dw_ff[i] <= 32'h0000_0000;
		end else begin
			cpu_irq_ff <= '0;
			if (wr_fire)
				cache_ok_ff <= 1'b0;
			unique case (state_ff)
				ST_IDLE: if (take) begin
					ch_ff      <= gnt_ch;
					chained_ff <= 1'b0;
					in_seq_ff  <= seq_hit;
					m_req_ff   <= 1'b1;
					widx_ff    <= 2'h0;
					if (seq_hit && pause_ff) begin
						daddr_ff <= resume_ff;
						m_cmd_ff <= mk_cmd(1'b0, SZ_LONG, resume_ff, 32'h0);
						state_ff <= ST_DREAD;
					end else if (oper_ff[`OP_RSKIP] && cache_ok_ff && cache_ch_ff == gnt_ch && !seq_hit) begin
						daddr_ff <= vaddr;
						m_cmd_ff <= mk_cmd(1'b0, sz, dw_ff[`W_SRC], 32'h0);
						state_ff <= ST_SRD;
					end else begin
						daddr_ff <= vaddr;
						m_cmd_ff <= mk_cmd(1'b0, SZ_LONG, vaddr, 32'h0);
						state_ff <= ST_DREAD;
					end
				end
				ST_DREAD: if (m_ack) begin
					dw_ff[widx_ff] <= ((widx_ff == `W_SRC || widx_ff == `W_DST) &&
						dw_ff[`W_MODE][`MA_SHORT]) ? sext_short(m_rdata) : m_rdata;
					if (widx_ff == `W_CNT) begin
						m_cmd_ff <= mk_cmd(1'b0, sz, dw_ff[`W_SRC], 32'h0);
						state_ff <= ST_SRD;
					end else begin
						widx_ff  <= widx_ff + 2'h1;
						m_cmd_ff <= mk_cmd(1'b0, SZ_LONG, daddr_ff + ({30'h0, widx_ff + 2'h1} << 2), 32'h0);
					end
				end
				ST_SRD: if (m_ack) begin
					data_ff  <= m_rdata & unit_mask(sz);
					m_cmd_ff <= mk_cmd(1'b1, sz, dw_ff[`W_DST], m_rdata & unit_mask(sz));
					state_ff <= ST_DWR;
				end
				ST_DWR: if (m_ack) begin
					dw_ff[`W_SRC] <= src_n;
					dw_ff[`W_DST] <= dst_n;
					dw_ff[`W_CNT] <= {cra_n, crb_n};
					if (in_seq_ff && dw_ff[`W_MODE][`MB_INDEX_TABLE_REF_BIT]) begin
						// First unit of a sequence trigger picks the index table entry
						m_cmd_ff <= mk_cmd(1'b0, SZ_LONG, ibase_ff + {22'h0, data_ff[7:0], 2'h0}, 32'h0);
						state_ff <= ST_SEL;
					end else if (md == XFER_BLOCK && !rld) begin
						m_cmd_ff <= mk_cmd(1'b0, sz, src_n, 32'h0);
						state_ff <= ST_SRD;
					end else begin
						m_req_ff <= 1'b0;
						widx_ff  <= `W_SRC;
						state_ff <= dw_ff[`W_MODE][`MA_WRITEBACK_DISABLE_BIT] ? ST_NEXT : ST_WB;
					end
				end
				ST_SEL: if (m_ack) begin
					daddr_ff   <= m_rdata;
					chained_ff <= 1'b1;
					widx_ff    <= 2'h0;
					m_cmd_ff   <= mk_cmd(1'b0, SZ_LONG, m_rdata, 32'h0);
					state_ff   <= ST_DREAD;
				end
				ST_WB: if (!m_req_ff) begin
					// Fixed addresses leave their words untouched in memory
					if ((widx_ff == `W_SRC && src_fix) ||
						(widx_ff == `W_DST && !dw_ff[`W_MODE][`MB_DINC])) begin
						widx_ff <= widx_ff + 2'h1;
					end else begin
						m_req_ff <= 1'b1;
						m_cmd_ff <= mk_cmd(1'b1, SZ_LONG, daddr_ff + ({30'h0, widx_ff} << 2),
							dw_ff[widx_ff]);
					end
				end else if (m_ack) begin
					m_req_ff <= 1'b0;
					if (widx_ff == `W_CNT)
						state_ff <= ST_NEXT;
					else
						widx_ff <= widx_ff + 2'h1;
				end
				ST_NEXT: begin
					if (!chained_ff && (dw_ff[`W_MODE][`MB_IRQEACH] || cnt_done))
						cpu_irq_ff[ch_ff] <= 1'b1;
					widx_ff <= 2'h0;
					if (in_seq_ff ? (!dw_ff[`W_MODE][`MB_SEQUENCE_END_BIT] && dw_ff[`W_MODE][`MB_CHAIN]) :
						(dw_ff[`W_MODE][`MB_CHAIN] && (!dw_ff[`W_MODE][`MB_CHZERO] || cnt_done))) begin
						daddr_ff   <= daddr_ff + `DESC_BYTES;
						chained_ff <= 1'b1;
						m_req_ff   <= 1'b1;
						m_cmd_ff   <= mk_cmd(1'b0, SZ_LONG, daddr_ff + `DESC_BYTES, 32'h0);
						state_ff   <= ST_DREAD;
					end else begin
						if (in_seq_ff) begin
							pause_ff  <= !dw_ff[`W_MODE][`MB_SEQUENCE_END_BIT];
							resume_ff <= daddr_ff + `DESC_BYTES;
						end
						cache_ok_ff <= !chained_ff && !in_seq_ff && !wr_fire;
						cache_ch_ff <= ch_ff;
						state_ff    <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule // transfer_engine

`default_nettype wire

// file: transfer_engine_tb_top.sv
// Self-checking bench of the transfer engine with a main-bus memory
`timescale 1ns/1ps
`default_nettype none
`include "engine_consts.svh"

module transfer_engine_tb_top
	import engine_pkg::*;
;
	typedef struct {logic [31:0] w0, sd, cnt, ed, ed2, ds, dd, e3;} row_s;
	logic        aclk = 1'b0, aresetn = 1'b0, seen;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, m_req_ff, m_ack;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  trig_in = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cpu_irq_ff;
	logic [1:0]  slow = 2'h0, s_axi_bresp, s_axi_rresp, r;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, m_rdata, s_axi_rdata, d, dsc, src, dst;
	mem_cmd_s    m_cmd_ff;
	int          fail_count = 0, comparisons = 0, cycles = 0;
	// Word 0, source data, count, then expected results
	row_s rows [7] = '{
		'{32'h2820_0000, 32'hA1B2_C3D4, 32'h0001_0000, 32'hA1B2_C3D4, 32'hFFFF_FFFF, 32'h4, 32'h4, 32'h0},
		'{32'h0800_0000, 32'h1234_565A, 32'h0001_0000, 32'hFFFF_FF5A, 32'hFFFF_FFFF, 32'h1, 32'h0, 32'h0},
		'{32'h1820_0000, 32'hCAFE_BEEF, 32'h0001_0000, 32'hFFFF_BEEF, 32'hFFFF_FFFF, 32'h2, 32'h2, 32'h0},
		'{32'h6802_0000, 32'h0F1E_2D3C, 32'h0101_0000, 32'h0F1E_2D3C, 32'hFFFF_FFFF, 32'h0, 32'h0,
			32'h0101_0000},
		'{32'hA830_0000, 32'h5566_7788, 32'h0202_0001, 32'h5566_7788, 32'h0, 32'h8, 32'h0, 32'h0202_0000},
		'{32'h2C20_0000, 32'h7766_5544, 32'h0001_0000, 32'h7766_5544, 32'hFFFF_FFFF, 32'h0, 32'h0,
			32'h0001_0000},
		'{32'h2000_0100, 32'h0A0B_0C0D, 32'h0001_0000, 32'h0A0B_0C0D, 32'hFFFF_FFFF, 32'h10, 32'h0, 32'h0}};
	// Chained pair of descriptors on the last channel, from 0x170 on
	logic [31:0] chain_t [8] = '{32'h28A0_0000, 32'h270, 32'h370, 32'h0001_0000, 32'h2820_0000,
		32'h280, 32'h380, 32'h0001_0000};

	transfer_engine transfer_engine_inst (.*);
	main_mem_model main_mem_model_inst (.*);
	////////////////////////////////////////////////////////////////////////////////
	// Clock and a watchdog that turns a hang into a failure
	initial begin
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			final_report();
		end
	end
	task final_report;
		if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Memory is loaded behind the bus; the engine must be idle meanwhile
	function logic [31:0] get_w(input logic [31:0] a);
		for (int k = 0; k < 4; k++) get_w[8*k +: 8] = main_mem_model_inst.mem[a[9:0] + k[9:0]];
	endfunction
	task put_w(input logic [31:0] a, input logic [31:0] v);
		for (int k = 0; k < 4; k++) main_mem_model_inst.mem[a[9:0] + k[9:0]] = v[8*k +: 8];
	endtask
	task load_row(input int i);
		dsc = 32'h100 + 16 * i;
		src = 32'h200 + 16 * i;
		dst = 32'h300 + 16 * i;
		put_w(dsc, rows[i].w0);
		put_w(dsc + 32'h4, src);
		put_w(dsc + 32'h8, dst);
		put_w(dsc + 32'hC, rows[i].cnt);
		put_w(src, rows[i].sd);
		put_w(src + 32'h4, 32'h0);
		put_w(dst, 32'hFFFF_FFFF);
		put_w(dst + 32'h4, 32'hFFFF_FFFF);
	endtask
	// Write: both offered together, each released at the edge it is taken
	task axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		axi_rd(a);
		chk(d, v);
		chk(32'(r), 32'(e));
	endtask
	task wr_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		axi_wr(a, v);
		chk(32'(r), 32'(e));
	endtask
	task pulse(input logic [7:0] m);
		@(posedge aclk);
		trig_in <= m;
		@(posedge aclk);
		trig_in <= 8'h00;
	endtask
	task wait_irq(input int ch);
		int n;
		n = 0;
		while (n < 3000 && cpu_irq_ff[ch] !== 1'b1) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(cpu_irq_ff[ch]), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Registers, table of transfers, stop, chaining
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 20; a += 4) rd_chk(a[7:0], 32'h0, `RESP_OKAY);
		rd_chk(8'h18, 32'h0, `RESP_SLVERR);
		wr_chk(`OFF_STAT, 32'h1, `RESP_SLVERR);
		wr_chk(`OFF_VBASE, 32'h100, `RESP_OKAY);
		rd_chk(`OFF_VBASE, 32'h100, `RESP_OKAY);
		wr_chk(`OFF_DISP, 32'h10, `RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			load_row(i);
			slow <= i[1:0];
			pulse(8'h01 << i);
			wait_irq(i);
			chk(get_w(dst), rows[i].ed);
			chk(get_w(dst + 32'h4), rows[i].ed2);
			chk(get_w(dsc + 32'h4), src + rows[i].ds);
			chk(get_w(dsc + 32'h8), dst + rows[i].dd);
			chk(get_w(dsc + 32'hC), rows[i].e3);
		end
		// Stopped engine latches both triggers but moves nothing
		load_row(1);
		load_row(0);
		wr_chk(`OFF_OPER, 32'h1, `RESP_OKAY);
		pulse(8'h03);
		seen = 1'b0;
		repeat (200) @(posedge aclk) seen = seen | (|cpu_irq_ff);
		chk(32'(seen), 32'h0);
		chk(get_w(dst), 32'hFFFF_FFFF);
		rd_chk(`OFF_STAT, 32'h0000_0300, `RESP_OKAY);
		wr_chk(`OFF_OPER, 32'h0, `RESP_OKAY);
		wait_irq(0);
		wait_irq(1);
		chk(get_w(dst), rows[0].ed);
		chk(get_w(32'h310), rows[1].ed);
		// One trigger runs two linked descriptors
		for (int k = 0; k < 8; k++) put_w(32'h170 + 4 * k, chain_t[k]);
		put_w(32'h270, 32'h1111_2222);
		put_w(32'h280, 32'h3333_4444);
		pulse(8'h80);
		wait_irq(7);
		do axi_rd(`OFF_STAT); while (d[0] !== 1'b0);
		chk(get_w(32'h370), 32'h1111_2222);
		chk(get_w(32'h380), 32'h3333_4444);
		final_report();
	end
endmodule // transfer_engine_tb_top
`default_nettype wire

// file: trigger_arbiter.sv
// Per-channel activation latches and fixed-priority grant
`timescale 1ns/1ps
`default_nettype none
`include "engine_consts.svh"

module trigger_arbiter (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`NCH-1:0]   trig,
	input  wire logic              take,
	input  wire logic [`CHW-1:0]   take_ch,
	output logic      [`NCH-1:0]   pend_ff,
	output logic                   gnt_valid,
	output logic      [`CHW-1:0]   gnt_ch
);
	// A new trigger in the cycle it is taken stays pending, so no request is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_ff <= '0;
		end else begin
			for (int i = 0; i < `NCH; i++) begin
				if (trig[i])
					pend_ff[i] <= 1'b1;
				else if (take && (take_ch == i[`CHW-1:0]))
					pend_ff[i] <= 1'b0;
			end
		end
	end

	// Lowest channel wins; a busy low channel can starve the high ones
	always_comb begin
		gnt_valid = 1'b0;
		gnt_ch    = '0;
		for (int i = `NCH-1; i >= 0; i--) begin
			if (pend_ff[i]) begin
				gnt_valid = 1'b1;
				gnt_ch    = i[`CHW-1:0];
			end
		end
	end
endmodule // trigger_arbiter

`default_nettype wire
